// ### logic/plssc_chain.sv
// plssc_chain: parallel-in serial-out shift chain with its host-facing serial port
// assumes: shift_clk comes from the host; clk is the local system clock for the taps
//
// Summary of operation
// R1: while load_strobe_n is low the eight taps are captured into the stages.
// R2: once load_strobe_n is high the taps no longer reach the stages, so the snapshot holds.
// R3: with load_strobe_n high, stages move only while shift_gate_n is low; with it high they hold.
// R4: one stage of advance happens per rising edge of shift_clk and at no other edge.
// R5: after eight qualifying shifts all channel bits are out and serial_in_chain shows at the output.
// R6: serial_in_chain feeds the first stage so devices cascade output to input.
// R7: the host reads two paralleled channels' bits as one channel's state.
// R8: capture while load_strobe_n is low ignores shift clock, shift gate and serial input; here the load still waits for a shift_clk rising edge.
// R9: a shift needs a rising edge with load high and gate low; with load high and no such shift, contents hold.
// R10: each shift moves every stage toward the output and the first stage takes serial_in_chain.
// R11: serial_out_chain always shows the last stage, so the first bit is readable after a load.
`timescale 1ns/100ps
module plssc_chain #(
	parameter int WIDTH = plssc_pkg::STAGE_COUNT
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] internal_parallel_taps,
	input  wire logic             shift_clk,
	input  wire logic             load_strobe_n,
	input  wire logic             shift_gate_n,
	input  wire logic             serial_in_chain,
	output logic                  serial_out_chain
);
	import plssc_pkg::*;

	// taps registered in the system domain, then a held copy for the link domain
	logic [WIDTH-1:0] tap_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tap_reg <= '0;
		end else begin
			tap_reg <= internal_parallel_taps;
		end
	end

	// taps reach the link side through a two-stage crossing (slow-moving filtered levels)
	logic [WIDTH-1:0] tap_meta;
	logic [WIDTH-1:0] tap_sync;
	always_ff @(posedge shift_clk or negedge rst_n) begin
		if (!rst_n) begin
			tap_meta <= '0;
			tap_sync <= '0;
		end else begin
			tap_meta <= tap_reg;
			tap_sync <= tap_meta;
		end
	end

	// mode choice on the host's own clock; load wins over everything
	logic [1:0] mode;
	always_comb begin
		if (!load_strobe_n) begin
			mode = MODE_LOAD;   // R1 R8
		end else if (!shift_gate_n) begin
			mode = MODE_SHIFT;  // R3 R9
		end else begin
			mode = MODE_HOLD;   // R2 R3
		end
	end

	logic [WIDTH-1:0] stages;
	plssc_stage_reg #(.WIDTH(WIDTH)) u_stages (
		.link_clk  (shift_clk),
		.rst_n     (rst_n),
		.mode      (mode),
		.load_data (tap_sync),
		.shift_in  (serial_in_chain),
		.stages    (stages)
	);

	// output is the last stage itself, a flip-flop
	always_comb begin
		serial_out_chain = stages[WIDTH-1]; // R11 R5
	end

	// shift counter for checking only
	logic [4:0] shift_cnt;
	always_ff @(posedge shift_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_cnt <= '0;
		end else if (!load_strobe_n) begin
			shift_cnt <= '0;
		end else if (!shift_gate_n && shift_cnt != 5'h1F) begin
			shift_cnt <= shift_cnt + 5'h01;
		end
	end

	load_capture_a: assert property (@(posedge shift_clk) disable iff (!rst_n) // R1
		!load_strobe_n |=> stages == $past(tap_sync))
		else $error("load did not capture taps");
	hold_gate_a: assert property (@(posedge shift_clk) disable iff (!rst_n) // R3
		(load_strobe_n && shift_gate_n) |=> $stable(stages))
		else $error("stages moved with gate high");
	shift_step_a: assert property (@(posedge shift_clk) disable iff (!rst_n) // R10
		(load_strobe_n && !shift_gate_n) |=> stages == {$past(stages[WIDTH-2:0]), $past(serial_in_chain)})
		else $error("shift step wrong");
	out_last_a: assert property (@(posedge shift_clk) disable iff (!rst_n) // R11
		serial_out_chain == stages[WIDTH-1])
		else $error("output not last stage");
	chain_through_a: assert property (@(posedge shift_clk) disable iff (!rst_n) // R5
		(load_strobe_n && !shift_gate_n) ##1 (load_strobe_n && !shift_gate_n)[*7]
		|=> serial_out_chain == $past(serial_in_chain, 8))
		else $error("serial input not at output after eight shifts");
	snapshot_hold_a: assert property (@(posedge shift_clk) disable iff (!rst_n) // R2
		(!load_strobe_n ##1 (load_strobe_n && shift_gate_n)) |=> stages == $past(stages))
		else $error("snapshot disturbed");
	first_bit_a: assert property (@(posedge shift_clk) disable iff (!rst_n) // R11
		!load_strobe_n |=> serial_out_chain == $past(tap_sync[WIDTH-1]))
		else $error("first bit not presented after load");
	count_clear_a: assert property (@(posedge shift_clk) disable iff (!rst_n) // R9
		!load_strobe_n |=> shift_cnt == 5'h00)
		else $error("shift count not cleared by load");
endmodule

// ### logic/plssc_pkg.sv
// plssc_pkg: constants for the parallel-load serial-shift chain
// assumes: shared by the chain top and its stage-register module
package plssc_pkg;
	localparam int STAGE_COUNT  = 8;          // register stages per device
	localparam int SYNC_DEPTH   = 2;          // flip-flops in each synchroniser
	localparam logic [7:0] STAGE_RESET = 8'h00; // stage contents after reset
	localparam logic [1:0] MODE_HOLD   = 2'h0;
	localparam logic [1:0] MODE_LOAD   = 2'h1;
	localparam logic [1:0] MODE_SHIFT  = 2'h3;
endpackage

// ### logic/plssc_stage_reg.sv
// plssc_stage_reg: the eight register stages, on the link clock
// assumes: mode and data are stable around the link clock rising edge
`timescale 1ns/100ps
module plssc_stage_reg #(
	parameter int WIDTH = plssc_pkg::STAGE_COUNT
) (
	input  wire logic             link_clk,
	input  wire logic             rst_n,
	input  wire logic [1:0]       mode,
	input  wire logic [WIDTH-1:0] load_data,
	input  wire logic             shift_in,
	output logic      [WIDTH-1:0] stages
);
	import plssc_pkg::*;

	// load, shift toward the top stage, or hold
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			stages <= '0;
		end else begin
			unique case (mode)
				MODE_LOAD:  stages <= load_data;                     // R1 R8
				MODE_SHIFT: stages <= {stages[WIDTH-2:0], shift_in}; // R4 R10 R6
				default:    stages <= stages;                        // R2 R9
			endcase
		end
	end
endmodule

// ### sim/plssc_host_model.sv
// plssc_host_model: host side of the serial port
// assumes: bench calls cycle once per 160 ns shift clock period
`timescale 1ns/100ps
module plssc_host_model (
	output logic      shift_clk = 1'b0,
	output logic      load_strobe_n = 1'b1,
	output logic      shift_gate_n = 1'b1,
	output logic      serial_in_chain = 1'b0,
	input  wire logic serial_out_chain
);
	// one clock period; the clock stands still between calls
	task automatic cycle(input logic ld_n, input logic g_n, input logic si, output logic so);
		load_strobe_n = ld_n;
		shift_gate_n = g_n;
		serial_in_chain = si;
		#77 shift_clk = 1'b1;
		#80 shift_clk = 1'b0;
		so = serial_out_chain;
		serial_in_chain = ~si; // released line shows no stale level
		#3;
	endtask
endmodule

// ### sim/test_parallel_load_serial_shift_chain.sv
// test_parallel_load_serial_shift_chain: checks the serial stream
// assumes: plssc_pkg and plssc_host_model compiled first
`timescale 1ns/100ps
module test_parallel_load_serial_shift_chain;
	import plssc_pkg::*;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] taps = 8'h00;
	logic       sclk, ld_n, g_n, si, so, got;
	int         n_errors = 0;
	int         comparisons = 0;
	// 100 MHz system clock
	always #5 clk = ~clk;
	plssc_chain i_dut (.clk(clk), .rst_n(rst_n), .internal_parallel_taps(taps), .shift_clk(sclk),
		.load_strobe_n(ld_n), .shift_gate_n(g_n), .serial_in_chain(si), .serial_out_chain(so));
	plssc_host_model i_host (.shift_clk(sclk), .load_strobe_n(ld_n), .shift_gate_n(g_n),
		.serial_in_chain(si), .serial_out_chain(so));
	task automatic check(input string what, input logic exp, input logic seen);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// new taps, then two idle shift clocks so they cross, then a load with gate low
	task automatic load(input logic [7:0] v);
		@(posedge clk) taps <= v;
		repeat (2) i_host.cycle(1'b1, 1'b1, 1'b0, got);
		i_host.cycle(1'b0, 1'b0, 1'b1, got);
		check("first bit", v[7], got);
	endtask
	// eight tap bits then eight cascade bits, taps moving meanwhile
	task automatic test_load_shift();
		logic [15:0] stream;
		stream = 16'hA5B2;
		load(stream[15:8]);
		@(posedge clk) taps <= 8'h5A;
		for (int n = 1; n <= 15; n++) begin
			i_host.cycle(1'b1, 1'b0, (n <= 8) ? stream[8-n] : 1'b0, got);
			check("stream bit", stream[15-n], got);
		end
		$display("load and shift done");
	endtask
	// gate high keeps the contents despite clock edges
	task automatic test_gate_hold();
		load(8'h9C);
		repeat (3) i_host.cycle(1'b1, 1'b1, 1'b0, got);
		check("held bit", 1'b1, got);
		i_host.cycle(1'b1, 1'b0, 1'b1, got);
		check("after hold", 1'b0, got);
		$display("gate hold done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		i_host.cycle(1'b1, 1'b1, 1'b0, got);
		@(posedge clk) rst_n <= 1'b1;
		test_load_shift();
		test_gate_hold();
		test_done();
	end
	// cuts a hang short
	initial begin
		#100000;
		n_errors++;
		test_done();
	end
endmodule
